// file: ebt_timer.sv
// four 8-bit timer counters on the internal data bus
// How it works
// - each counter is an 8-bit up-counter stepping once per internal tick or selected pin edge (rise, fall or both) its clock select picks.
// - the cpu may read any counter at any time and write it at any time outside standby, running or not.
// - counters 0 and 1, and 2 and 3, are reachable together as one 16-bit word.
// - a counter clears on the capture or match event its 2-bit clear select picks.
// - rolling from the maximum to zero sets that counter's rollover flag.
// - reset and standby force every counter to zero.
module ebt_timer (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic standby,
   input ebt_pkg::ebt_ctrl_t [3:0] timer_control,
   input ebt_pkg::ebt_clr_evt_t [3:0] clr_evt,
   input wire logic [2:0] int_tick,
   input wire logic [3:0] ext_clk_pin,
   input wire logic [3:0] rollover_clr,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic bus_word,
   input wire logic [1:0] bus_idx,
   input wire logic [15:0] bus_wdata,
   output logic [15:0] bus_rdata,
   output logic [3:0] rollover_flag,
   output logic [31:0] count_all
);
   // ==========================================
   // external clock pin synchronisers
   logic [3:0] ext_s1_r;
   logic [3:0] ext_s2_r;
   logic [3:0] ext_s3_r;
   logic [3:0] ext_s1_nxt;
   logic [3:0] ext_s2_nxt;
   logic [3:0] ext_s3_nxt;
   always_comb begin
      ext_s1_nxt = ext_clk_pin;
      ext_s2_nxt = ext_s1_r;
      ext_s3_nxt = ext_s2_r;
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ext_s1_r <= 4'h0;
         ext_s2_r <= 4'h0;
         ext_s3_r <= 4'h0;
      end else begin
         ext_s1_r <= ext_s1_nxt;
         ext_s2_r <= ext_s2_nxt;
         ext_s3_r <= ext_s3_nxt;
      end
   end

   // ==========================================
   // edge detector priming
   // pin level after reset is unknown: no edge is seen until
   // every stage holds a real pin sample
   logic [2:0] prime_r;
   logic [2:0] prime_nxt;
   logic [3:0] ext_prev;
   always_comb begin
      prime_nxt = {prime_r[1:0], 1'b1};
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prime_r <= 3'h0;
      end else begin
         prime_r <= prime_nxt;
      end
   end
   always_comb begin
      ext_prev = ext_s3_r;
      if (!prime_r[2]) begin
         ext_prev = ext_s2_r;
      end
   end

   // ==========================================
   // bus write decode
   logic [3:0] wr_en;
   logic [7:0] wr_byte [4];
   logic [7:0] cnt [4];
   logic [3:0] flag;
   logic [2:0] acc_kind;
   assign acc_kind = {bus_word, bus_idx};
   always_comb begin
      wr_en = 4'h0;
      for (int i = 0; i < ebt_pkg::NUM_CNT; i++) begin
         wr_byte[i] = bus_wdata[7:0];
      end
      if (bus_wr) begin
         case (acc_kind)
            {1'b0, ebt_pkg::IDX_COUNT_0}: begin
               wr_en[ebt_pkg::IDX_COUNT_0] = 1'b1;
            end
            {1'b0, ebt_pkg::IDX_COUNT_1}: begin
               wr_en[ebt_pkg::IDX_COUNT_1] = 1'b1;
            end
            {1'b0, ebt_pkg::IDX_COUNT_2}: begin
               wr_en[ebt_pkg::IDX_COUNT_2] = 1'b1;
            end
            {1'b0, ebt_pkg::IDX_COUNT_3}: begin
               wr_en[ebt_pkg::IDX_COUNT_3] = 1'b1;
            end
            {1'b1, ebt_pkg::IDX_COUNT_0}, {1'b1, ebt_pkg::IDX_COUNT_1}: begin
               // high byte to the even counter, low byte to the odd one
               wr_en[ebt_pkg::IDX_COUNT_0] = 1'b1;
               wr_en[ebt_pkg::IDX_COUNT_1] = 1'b1;
               wr_byte[ebt_pkg::IDX_COUNT_0] = bus_wdata[15:8];
            end
            {1'b1, ebt_pkg::IDX_COUNT_2}, {1'b1, ebt_pkg::IDX_COUNT_3}: begin
               wr_en[ebt_pkg::IDX_COUNT_2] = 1'b1;
               wr_en[ebt_pkg::IDX_COUNT_3] = 1'b1;
               wr_byte[ebt_pkg::IDX_COUNT_2] = bus_wdata[15:8];
            end
            default: begin
               wr_en = 4'h0;
            end
         endcase
      end
   end

   // ==========================================
   // counter channels
   ebt_channel u_ebt_channel_0 (
      .clk(clk),
      .sys_rst(sys_rst),
      .standby(standby),
      .ctrl(timer_control[0]),
      .clr_evt(clr_evt[0]),
      .int_tick(int_tick),
      .ext_lvl(ext_s2_r[0]),
      .ext_prev(ext_prev[0]),
      .wr_en(wr_en[0]),
      .wr_data(wr_byte[0]),
      .flag_clr(rollover_clr[0]),
      .count_value(cnt[0]),
      .rollover_flag(flag[0])
   );

   ebt_channel u_ebt_channel_1 (
      .clk(clk),
      .sys_rst(sys_rst),
      .standby(standby),
      .ctrl(timer_control[1]),
      .clr_evt(clr_evt[1]),
      .int_tick(int_tick),
      .ext_lvl(ext_s2_r[1]),
      .ext_prev(ext_prev[1]),
      .wr_en(wr_en[1]),
      .wr_data(wr_byte[1]),
      .flag_clr(rollover_clr[1]),
      .count_value(cnt[1]),
      .rollover_flag(flag[1])
   );

   ebt_channel u_ebt_channel_2 (
      .clk(clk),
      .sys_rst(sys_rst),
      .standby(standby),
      .ctrl(timer_control[2]),
      .clr_evt(clr_evt[2]),
      .int_tick(int_tick),
      .ext_lvl(ext_s2_r[2]),
      .ext_prev(ext_prev[2]),
      .wr_en(wr_en[2]),
      .wr_data(wr_byte[2]),
      .flag_clr(rollover_clr[2]),
      .count_value(cnt[2]),
      .rollover_flag(flag[2])
   );

   ebt_channel u_ebt_channel_3 (
      .clk(clk),
      .sys_rst(sys_rst),
      .standby(standby),
      .ctrl(timer_control[3]),
      .clr_evt(clr_evt[3]),
      .int_tick(int_tick),
      .ext_lvl(ext_s2_r[3]),
      .ext_prev(ext_prev[3]),
      .wr_en(wr_en[3]),
      .wr_data(wr_byte[3]),
      .flag_clr(rollover_clr[3]),
      .count_value(cnt[3]),
      .rollover_flag(flag[3])
   );

   // ==========================================
   // read data and registered outputs
   logic [15:0] rdata_r;
   logic [15:0] rdata_nxt;
   always_comb begin
      rdata_nxt = rdata_r;
      if (bus_rd) begin
         case (acc_kind)
            {1'b0, ebt_pkg::IDX_COUNT_0}: begin
               rdata_nxt = {8'h00, cnt[ebt_pkg::IDX_COUNT_0]};
            end
            {1'b0, ebt_pkg::IDX_COUNT_1}: begin
               rdata_nxt = {8'h00, cnt[ebt_pkg::IDX_COUNT_1]};
            end
            {1'b0, ebt_pkg::IDX_COUNT_2}: begin
               rdata_nxt = {8'h00, cnt[ebt_pkg::IDX_COUNT_2]};
            end
            {1'b0, ebt_pkg::IDX_COUNT_3}: begin
               rdata_nxt = {8'h00, cnt[ebt_pkg::IDX_COUNT_3]};
            end
            {1'b1, ebt_pkg::IDX_COUNT_0}, {1'b1, ebt_pkg::IDX_COUNT_1}: begin
               rdata_nxt = {cnt[ebt_pkg::IDX_COUNT_0], cnt[ebt_pkg::IDX_COUNT_1]};
            end
            {1'b1, ebt_pkg::IDX_COUNT_2}, {1'b1, ebt_pkg::IDX_COUNT_3}: begin
               rdata_nxt = {cnt[ebt_pkg::IDX_COUNT_2], cnt[ebt_pkg::IDX_COUNT_3]};
            end
            default: begin
               rdata_nxt = rdata_r;
            end
         endcase
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata_r <= 16'h0000;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end
   assign bus_rdata = rdata_r;
   assign rollover_flag = flag;
   assign count_all = {cnt[3], cnt[2], cnt[1], cnt[0]};
endmodule

// file: ebt_pkg.sv
// package for the four 8-bit timer counters
package ebt_pkg;
   localparam int unsigned NUM_CNT = 4;
   localparam int unsigned CNT_W = 8;
   localparam logic [7:0] CNT_RESET = 8'h00;
   localparam logic [7:0] CNT_MAX = 8'hff;
   localparam logic [7:0] CNT_ONE = 8'h01;
   // register indices on the internal data bus
   localparam logic [1:0] IDX_COUNT_0 = 2'h0;
   localparam logic [1:0] IDX_COUNT_1 = 2'h1;
   localparam logic [1:0] IDX_COUNT_2 = 2'h2;
   localparam logic [1:0] IDX_COUNT_3 = 2'h3;
   // clock select codes
   localparam logic [2:0] CKS_STOP = 3'h0;
   localparam logic [2:0] CKS_INT0 = 3'h1;
   localparam logic [2:0] CKS_INT1 = 3'h2;
   localparam logic [2:0] CKS_INT2 = 3'h3;
   localparam logic [2:0] CKS_EXT_RISE = 3'h5;
   localparam logic [2:0] CKS_EXT_FALL = 3'h6;
   localparam logic [2:0] CKS_EXT_BOTH = 3'h7;
   // clear select codes
   localparam logic [1:0] CLR_NONE = 2'h0;
   localparam logic [1:0] CLR_MATCH_A = 2'h1;
   localparam logic [1:0] CLR_MATCH_B = 2'h2;
   localparam logic [1:0] CLR_CAPTURE = 2'h3;

   typedef struct packed {
      logic [2:0] clock_select;
      logic [1:0] clear_select;
   } ebt_ctrl_t;

   typedef struct packed {
      logic match_a;
      logic match_b;
      logic capture;
   } ebt_clr_evt_t;
endpackage

// file: ebt_channel.sv
// one 8-bit up-counter with clock select, clear select and rollover flag
module ebt_channel (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic standby,
   input ebt_pkg::ebt_ctrl_t ctrl,
   input ebt_pkg::ebt_clr_evt_t clr_evt,
   input wire logic [2:0] int_tick,
   input wire logic ext_lvl,
   input wire logic ext_prev,
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   input wire logic flag_clr,
   output logic [7:0] count_value,
   output logic rollover_flag
);
   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;
   logic flag_r;
   logic flag_nxt;
   logic tick;
   logic clr_hit;

   always_comb begin
      case (ctrl.clock_select)
         ebt_pkg::CKS_INT0: tick = int_tick[0];
         ebt_pkg::CKS_INT1: tick = int_tick[1];
         ebt_pkg::CKS_INT2: tick = int_tick[2];
         ebt_pkg::CKS_EXT_RISE: tick = ext_lvl & ~ext_prev;
         ebt_pkg::CKS_EXT_FALL: tick = ~ext_lvl & ext_prev;
         ebt_pkg::CKS_EXT_BOTH: tick = ext_lvl ^ ext_prev;
         default: tick = 1'b0;
      endcase
      case (ctrl.clear_select)
         ebt_pkg::CLR_MATCH_A: clr_hit = clr_evt.match_a;
         ebt_pkg::CLR_MATCH_B: clr_hit = clr_evt.match_b;
         ebt_pkg::CLR_CAPTURE: clr_hit = clr_evt.capture;
         default: clr_hit = 1'b0;
      endcase
      cnt_nxt = cnt_r;
      flag_nxt = flag_r;
      if (flag_clr) begin
         flag_nxt = 1'b0;
      end
      if (standby) begin
         cnt_nxt = ebt_pkg::CNT_RESET;
      end else if (wr_en) begin
         cnt_nxt = wr_data;
      end else if (clr_hit) begin
         cnt_nxt = ebt_pkg::CNT_RESET;
      end else if (tick) begin
         cnt_nxt = cnt_r + ebt_pkg::CNT_ONE;
         if (cnt_r == ebt_pkg::CNT_MAX) begin
            flag_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt_r <= ebt_pkg::CNT_RESET;
         flag_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         flag_r <= flag_nxt;
      end
   end

   assign count_value = cnt_r;
   assign rollover_flag = flag_r;
endmodule

// file: ebt_cpu_model.sv
// cpu side of the internal data bus
module ebt_cpu_model (
   output logic bus_wr,
   output logic bus_rd,
   output logic bus_word,
   output logic [1:0] bus_idx,
   output logic [15:0] bus_wdata,
   input wire logic clk
);
   timeunit 1ns / 1ps;
   initial {bus_wr, bus_rd, bus_word, bus_idx, bus_wdata} = '0;
   task automatic acc(input logic w, r, b, input logic [1:0] a, input logic [15:0] d);
      @(posedge clk);
      {bus_wr, bus_rd, bus_word, bus_idx, bus_wdata} <= {w, r, b, a, d};
      @(posedge clk);
      {bus_wr, bus_rd, bus_idx, bus_wdata} <= {2'h0, ~a, ~d};
   endtask
endmodule

// file: ebt_timer_chk.sv
// timer counter checker
module ebt_timer_chk (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic standby,
   input ebt_pkg::ebt_ctrl_t [3:0] timer_control,
   input ebt_pkg::ebt_clr_evt_t [3:0] clr_evt,
   input wire logic [2:0] int_tick,
   input wire logic [3:0] rollover_clr,
   input wire logic bus_wr,
   input wire logic bus_word,
   input wire logic [1:0] bus_idx,
   input wire logic [15:0] bus_wdata,
   input wire logic [3:0] rollover_flag,
   input wire logic [31:0] count_all
);
   timeunit 1ns / 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   wire quiet = !bus_wr && !standby;
   wire inc0 = quiet && timer_control[0].clock_select == 3'h1 && int_tick[0] && !clr_evt[0];
   property p_step; inc0 |=> count_all[7:0] == $past(count_all[7:0]) + 8'h01; endproperty
   a_step: assert property (p_step) else $error("no step");
   property p_wr; bus_wr && !standby && bus_idx == 2'h0 |=> count_all[7:0] ==
      $past(bus_word ? bus_wdata[15:8] : bus_wdata[7:0]); endproperty
   a_wr: assert property (p_wr) else $error("write lost");
   property p_pair; bus_wr && bus_word && !bus_idx[1] && !standby |=> count_all[15:8] ==
      $past(bus_wdata[7:0]); endproperty
   a_pair: assert property (p_pair) else $error("word lost");
   property p_clr; quiet && timer_control[1].clear_select == 2'h3 && clr_evt[1].capture |=>
      count_all[15:8] == 8'h00; endproperty
   a_clr: assert property (p_clr) else $error("no clear");
   property p_ovf; inc0 && count_all[7:0] == 8'hff |=> rollover_flag[0]; endproperty
   a_ovf: assert property (p_ovf) else $error("no flag");
   property p_stby; standby |=> count_all == 32'h0; endproperty
   a_stby: assert property (p_stby) else $error("not zeroed");
   property p_keep; rollover_flag[0] && !rollover_clr[0] |=> rollover_flag[0]; endproperty
   a_keep: assert property (p_keep) else $error("flag lost");
endmodule
bind ebt_timer ebt_timer_chk u_ebt_timer_chk (.*);

// file: ebt_timer_tb.sv
// timer counter bench
module ebt_timer_tb;
   timeunit 1ns / 1ps;
   logic clk, sys_rst, standby, bus_wr, bus_rd, bus_word, rd_d;
   logic [1:0] bus_idx;
   logic [2:0] int_tick;
   logic [3:0] rollover_clr, rollover_flag, ext_clk_pin;
   logic [15:0] bus_wdata, bus_rdata, d;
   logic [16:0] n, q[$];
   logic [31:0] count_all;
   ebt_pkg::ebt_ctrl_t [3:0] timer_control;
   ebt_pkg::ebt_clr_evt_t [3:0] clr_evt;
   int err_count, num_checks, i, seed = 32'h01b6;
   ebt_cpu_model u_ebt_cpu_model (.*);
   ebt_timer u_ebt_timer (.*);
   task automatic chk(input logic [31:0] g, e);
      num_checks++;
      if (g !== e) err_count++;
      if (g !== e) $display("[ERR] %0t %h %h", $time, g, e);
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic rd(input logic [1:0] a, input logic w, input logic [15:0] e);
      q.push_back({w, e});
      u_ebt_cpu_model.acc(1'b0, 1'b1, w, a, 16'h0);
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      rd_d <= bus_rd;
      if (rd_d) begin
         n = q.pop_front();
         chk(bus_rdata, n[15:0]);
      end
   end
   initial begin
      sys_rst = 1'b1;
      {standby, ext_clk_pin, int_tick, rollover_clr, clr_evt} = '0;
      timer_control = 20'h00064; // c0 steps on int_tick[0], c1 clears on capture
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      chk(count_all, 32'h0);
      for (i = 0; i < 5; i++) begin
         d = 16'($random(seed));
         u_ebt_cpu_model.acc(1'b1, 1'b0, i[2], i[1:0], d);
         rd(i[1:0], i[2], i[2] ? d : {8'h00, d[7:0]});
      end
      u_ebt_cpu_model.acc(1'b1, 1'b0, 1'b1, 2'h0, 16'hffa5);
      int_tick <= 3'h1;
      repeat (2) @(posedge clk);
      int_tick <= 3'h0;
      @(posedge clk);
      chk({rollover_flag, count_all[7:0]}, 32'h101);
      rollover_clr <= 4'h1;
      clr_evt[1].capture <= 1'b1;
      @(posedge clk);
      {rollover_clr, clr_evt} <= '0;
      @(posedge clk);
      chk({rollover_flag, count_all[15:8]}, 32'h0);
      standby <= 1'b1;
      @(posedge clk);
      standby <= 1'b0;
      @(posedge clk);
      chk(count_all, 32'h0);
      // c3 ext fall, c2 ext rise, c1 int_tick[2] on match_b, c0 int_tick[1] on match_a
      timer_control <= {5'h18, 5'h14, 5'h0e, 5'h09};
      int_tick <= 3'h6;
      ext_clk_pin <= 4'hc;
      repeat (3) @(posedge clk);
      int_tick <= 3'h0;
      ext_clk_pin <= 4'h0;
      repeat (4) @(posedge clk);
      chk(count_all, 32'h01010303);
      clr_evt[0].match_a <= 1'b1;
      clr_evt[1].match_b <= 1'b1;
      clr_evt[2].capture <= 1'b1;
      @(posedge clk);
      clr_evt <= '0;
      @(posedge clk);
      chk(count_all, 32'h01010000);
      // c3 on both edges
      timer_control[3] <= 5'h1c;
      ext_clk_pin <= 4'h8;
      repeat (4) @(posedge clk);
      ext_clk_pin <= 4'h0;
      repeat (5) @(posedge clk);
      chk(count_all[31:24], 32'h03);
      // pins high across reset: no false edge after release
      ext_clk_pin <= 4'hc;
      sys_rst <= 1'b1;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (5) @(posedge clk);
      chk(count_all, 32'h0);
      chk(q.size(), 32'h0);
      stop_test();
   end
endmodule
